// file: rtl/spbr_dev.sv
module spbr_dev
  import spbr_pkg::*;
(
  // Clock and reset.
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  // Link to the host.
  spbr_spi_if.dev   bus,
  // I2C open-drain pins.
  input  wire logic scl_i,
  output logic      scl_o,
  output logic      scl_oe_o,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o
);

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_START = 4'b0010,
    S_BIT   = 4'b0100,
    S_STOP  = 4'b1000
  } spbr_i2c_e;

  typedef struct packed {
    logic [2:0]                            sclk_s;
    logic [2:0]                            mosi_s;
    logic [2:0]                            cs_s;
    logic [2:0]                            scl_s;
    logic [2:0]                            sda_s;
    logic                                  sclk_f;
    logic                                  mosi_f;
    logic                                  cs_f;
    logic                                  scl_f;
    logic                                  sda_f;
    logic [7:0]                            rx_sr;
    logic [2:0]                            bit_cnt;
    logic [8:0]                            idx;
    logic [7:0]                            opcode;
    logic [7:0]                            arg;
    logic [7:0]                            tx_sr;
    logic                                  miso;
    logic                                  lsb_first;
    logic                                  int_n;
    logic [7:0]                            clk_div;
    logic [7:0]                            time_limit;
    logic [7:0]                            outcome;
    logic [7:0]                            wr_cnt;
    logic [7:0]                            tgt;
    logic [MAX_WRITE_BYTES-1:0][7:0]       data_buf;
    spbr_i2c_e                             st;
    logic [1:0]                            phase;
    logic [14:0]                           qtmr;
    logic [7:0]                            bsr;
    logic [3:0]                            bcnt;
    logic [7:0]                            didx;
    logic [7:0]                            res;
    logic                                  scl_oe;
    logic                                  sda_oe;
    logic [4:0]                            to_pre;
    logic [25:0]                           to_cnt;
  } spbr_dev_s;

  spbr_dev_s r;
  spbr_dev_s n;
  spbr_dev_s rst_val;

  logic        sclk_nf;
  logic        mosi_nf;
  logic        cs_nf;
  logic        scl_nf;
  logic        sda_nf;
  logic        rise;
  logic        fall;
  logic        tick;
  logic        busy;
  logic [7:0]  rxb;
  logic [14:0] qv;
  logic [16:0] prod;

  always_comb begin
    rst_val            = '0;
    rst_val.sclk_s     = SYNC_HI;
    rst_val.cs_s       = SYNC_HI;
    rst_val.scl_s      = SYNC_HI;
    rst_val.sda_s      = SYNC_HI;
    rst_val.sclk_f     = 1'b1;
    rst_val.cs_f       = 1'b1;
    rst_val.scl_f      = 1'b1;
    rst_val.sda_f      = 1'b1;
    rst_val.miso       = 1'b1;
    rst_val.int_n      = 1'b1;
    rst_val.clk_div    = RST_I2C_CLOCK;
    rst_val.time_limit = RST_TIME_LIMIT;
    rst_val.outcome    = RST_OUTCOME;
    rst_val.st         = S_IDLE;
  end

  always_comb begin
    n        = r;
    sclk_nf  = (r.sclk_s[1] == r.sclk_s[2]) ? r.sclk_s[2] : r.sclk_f;
    mosi_nf  = (r.mosi_s[1] == r.mosi_s[2]) ? r.mosi_s[2] : r.mosi_f;
    cs_nf    = (r.cs_s[1] == r.cs_s[2]) ? r.cs_s[2] : r.cs_f;
    scl_nf   = (r.scl_s[1] == r.scl_s[2]) ? r.scl_s[2] : r.scl_f;
    sda_nf   = (r.sda_s[1] == r.sda_s[2]) ? r.sda_s[2] : r.sda_f;
    rise     = sclk_nf & ~r.sclk_f & ~cs_nf;
    fall     = ~sclk_nf & r.sclk_f & ~cs_nf;
    tick     = (r.qtmr == 15'h0000);
    busy     = (r.st != S_IDLE);
    rxb      = r.lsb_first ? {mosi_nf, r.rx_sr[7:1]} : {r.rx_sr[6:0], mosi_nf};
    qv       = 15'(r.clk_div) * I2C_Q_SCALE;
    if (qv < I2C_Q_MIN_CYC) begin
      qv = I2C_Q_MIN_CYC;
    end
    prod     = ({9'h000, r.clk_div} + 17'h00001) * ({10'h000, r.time_limit[7:1]} + 17'h00001);

    n.sclk_s = {r.sclk_s[1:0], bus.sclk};
    n.mosi_s = {r.mosi_s[1:0], bus.mosi};
    n.cs_s   = {r.cs_s[1:0], bus.cs_n};
    n.scl_s  = {r.scl_s[1:0], scl_i};
    n.sda_s  = {r.sda_s[1:0], sda_i};
    n.sclk_f = sclk_nf;
    n.mosi_f = mosi_nf;
    n.cs_f   = cs_nf;
    n.scl_f  = scl_nf;
    n.sda_f  = sda_nf;

    // A new selection restarts framing and withdraws a pending interrupt.
    if (!cs_nf && r.cs_f) begin
      n.idx     = 9'h000;
      n.bit_cnt = 3'h0;
      n.int_n   = 1'b1;
    end

    if (rise) begin
      n.rx_sr   = rxb;
      n.bit_cnt = r.bit_cnt + 3'h1;
      if (r.bit_cnt == 3'h7) begin
        if (r.idx != 9'h1ff) begin
          n.idx = r.idx + 9'h001;
        end
        if (r.idx == 9'h000) begin
          n.opcode = rxb;
        end else if (r.opcode == OP_I2C_WRITE && !busy) begin
          if (r.idx == 9'h001) begin
            n.wr_cnt = rxb;
          end else if (r.idx == 9'h002) begin
            n.tgt = rxb;
          end else if (r.idx <= LAST_DATA_IDX) begin
            n.data_buf[8'(r.idx - FIRST_DATA_IDX)] = rxb;
          end
        end else if (r.opcode == OP_REG_READ && r.idx == 9'h001) begin
          n.arg = rxb;
          if (rxb == REG_I2C_CLOCK) begin
            n.tx_sr = r.clk_div;
          end else if (rxb == REG_TIME_LIMIT) begin
            n.tx_sr = r.time_limit;
          end else if (rxb == REG_OUTCOME) begin
            n.tx_sr = r.outcome;
          end else begin
            n.tx_sr = 8'h00;
          end
        end else if (r.opcode == OP_REG_WRITE) begin
          if (r.idx == 9'h001) begin
            n.arg = rxb;
          end else if (r.idx == 9'h002 && r.arg == REG_I2C_CLOCK) begin
            n.clk_div = rxb;
          end else if (r.idx == 9'h002 && r.arg == REG_TIME_LIMIT) begin
            n.time_limit = rxb;
          end
        end else if (r.opcode == OP_SPI_CFG && r.idx == 9'h001) begin
          if (rxb == CFG_LSB_FIRST) begin
            n.lsb_first = 1'b1;
          end else if (rxb == CFG_MSB_FIRST) begin
            n.lsb_first = 1'b0;
          end
        end
      end
    end

    if (fall) begin
      n.miso  = r.lsb_first ? r.tx_sr[0] : r.tx_sr[7];
      n.tx_sr = r.lsb_first ? {1'b0, r.tx_sr[7:1]} : {r.tx_sr[6:0], 1'b0};
    end

    // Deselection ends a write command; a complete one starts the transfer.
    if (cs_nf && !r.cs_f && r.opcode == OP_I2C_WRITE && r.idx >= FIRST_DATA_IDX && !busy) begin
      if (r.wr_cnt == 8'h00 || {1'b0, r.wr_cnt} > (r.idx - FIRST_DATA_IDX)) begin
        n.outcome = ST_BAD_COUNT;
        n.int_n   = 1'b0;
      end else begin
        n.outcome = ST_BUSY;
        n.st      = S_START;
        n.phase   = 2'h0;
        n.qtmr    = qv;
        n.to_pre  = 5'h00;
        n.to_cnt  = 26'h0000000;
      end
    end

    if (!tick) begin
      n.qtmr = r.qtmr - 15'h0001;
    end

    case (r.st)
      S_START: begin
        if (r.phase == 2'h0) begin
          if (!(scl_nf && sda_nf)) begin
            n.qtmr = qv;
          end else if (tick) begin
            n.sda_oe = 1'b1;
            n.phase  = 2'h1;
            n.qtmr   = qv;
          end
        end else if (tick) begin
          n.scl_oe = 1'b1;
          n.st     = S_BIT;
          n.phase  = 2'h0;
          n.qtmr   = qv;
          n.bsr    = {r.tgt[7:1], 1'b0};
          n.bcnt   = 4'h0;
          n.didx   = 8'h00;
        end
      end
      S_BIT: begin
        case (r.phase)
          2'h0: begin
            if (tick) begin
              n.sda_oe = (r.bcnt[3] == 1'b0) ? ~r.bsr[7] : 1'b0;
              n.phase  = 2'h1;
              n.qtmr   = qv;
            end
          end
          2'h1: begin
            if (tick) begin
              n.scl_oe = 1'b0;
              n.phase  = 2'h2;
              n.qtmr   = qv;
            end
          end
          2'h2: begin
            if (!scl_nf) begin
              n.qtmr = qv;
            end else begin
              n.phase = 2'h3;
              n.qtmr  = {qv[13:0], 1'b0};
            end
          end
          default: begin
            if (r.bcnt[3] == 1'b0 && !r.sda_oe && !sda_nf) begin
              n.scl_oe = 1'b0;
              n.sda_oe = 1'b0;
              n.st     = S_START;
              n.phase  = 2'h0;
              n.qtmr   = qv;
            end else if (tick || !scl_nf) begin
              n.scl_oe = 1'b1;
              n.phase  = 2'h0;
              n.qtmr   = qv;
              if (r.bcnt[3] == 1'b0) begin
                n.bcnt = r.bcnt + 4'h1;
                n.bsr  = {r.bsr[6:0], 1'b0};
              end else if (sda_nf) begin
                n.res = (r.didx == 8'h00) ? ST_ADDR_NAK : ST_DATA_NAK;
                n.st  = S_STOP;
              end else if (r.didx == r.wr_cnt) begin
                n.res = ST_OK;
                n.st  = S_STOP;
              end else begin
                n.bsr  = r.data_buf[r.didx];
                n.didx = r.didx + 8'h01;
                n.bcnt = 4'h0;
              end
            end
          end
        endcase
      end
      S_STOP: begin
        case (r.phase)
          2'h0: begin
            if (tick) begin
              n.sda_oe = 1'b1;
              n.phase  = 2'h1;
              n.qtmr   = qv;
            end
          end
          2'h1: begin
            if (tick) begin
              n.scl_oe = 1'b0;
              n.phase  = 2'h2;
              n.qtmr   = qv;
            end
          end
          2'h2: begin
            if (!scl_nf) begin
              n.qtmr = qv;
            end else if (tick) begin
              n.sda_oe = 1'b0;
              n.phase  = 2'h3;
              n.qtmr   = qv;
            end
          end
          default: begin
            if (tick) begin
              n.st      = S_IDLE;
              n.outcome = r.res;
              n.int_n   = 1'b0;
            end
          end
        endcase
      end
      default: begin
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
      end
    endcase

    // The time limit covers the whole transfer, retries after lost arbitration included.
    if (busy && r.time_limit[0]) begin
      n.to_pre = (r.to_pre == TO_TICK_CYC - 5'h01) ? 5'h00 : r.to_pre + 5'h01;
      if (r.to_pre == TO_TICK_CYC - 5'h01) begin
        n.to_cnt = r.to_cnt + 26'h0000001;
      end
      if (r.to_cnt >= {prod, 9'h000}) begin
        n.st      = S_IDLE;
        n.scl_oe  = 1'b0;
        n.sda_oe  = 1'b0;
        n.outcome = ST_TIMEOUT;
        n.int_n   = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      r <= rst_val;
    end else begin
      r <= n;
    end
  end

  assign bus.miso  = r.miso;
  assign bus.int_n = r.int_n;
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe_o  = r.scl_oe;
  assign sda_oe_o  = r.sda_oe;

endmodule

// file: rtl/spbr_host.sv
module spbr_host
  import spbr_pkg::*;
(
  // Clock and reset.
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  // Command port.
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Link to the bridge.
  spbr_spi_if.host        bus
);

  typedef struct packed {
    logic [2:0] miso_s;
    logic [2:0] int_s;
    logic       miso_f;
    logic       int_f;
    logic       sel;
    logic       lsb_first;
    logic       busy;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [3:0] bcnt;
    logic [7:0] hcnt;
    logic       sclk;
    logic       mosi;
    logic [7:0] rdata;
  } spbr_host_s;

  spbr_host_s r;
  spbr_host_s n;
  spbr_host_s rst_val;

  logic miso_nf;
  logic int_nf;

  always_comb begin
    rst_val        = '0;
    rst_val.miso_s = SYNC_HI;
    rst_val.int_s  = SYNC_HI;
    rst_val.miso_f = 1'b1;
    rst_val.int_f  = 1'b1;
    rst_val.sclk   = 1'b1;
    rst_val.mosi   = 1'b1;
  end

  always_comb begin
    n        = r;
    miso_nf  = (r.miso_s[1] == r.miso_s[2]) ? r.miso_s[2] : r.miso_f;
    int_nf   = (r.int_s[1] == r.int_s[2]) ? r.int_s[2] : r.int_f;
    n.miso_s = {r.miso_s[1:0], bus.miso};
    n.int_s  = {r.int_s[1:0], bus.int_n};
    n.miso_f = miso_nf;
    n.int_f  = int_nf;
    n.rdata  = 8'h00;

    if (wr_i) begin
      if (addr_i == HREG_CTRL) begin
        n.sel       = wdata_i[0];
        n.lsb_first = wdata_i[1];
      end else if (addr_i == HREG_TX && r.sel && !r.busy) begin
        n.busy = 1'b1;
        n.tx   = wdata_i;
        n.bcnt = 4'h0;
        n.hcnt = SPI_HALF_CYC;
      end
    end

    if (rd_i) begin
      if (addr_i == HREG_CTRL) begin
        n.rdata = {6'h00, r.lsb_first, r.sel};
      end else if (addr_i == HREG_RX) begin
        n.rdata = r.rx;
      end else if (addr_i == HREG_STAT) begin
        n.rdata = {6'h00, ~int_nf, r.busy};
      end
    end

    // Each half period lasts at least SPI_HALF_CYC cycles to keep the link at or under its top rate.
    if (r.busy) begin
      if (r.hcnt != 8'h00) begin
        n.hcnt = r.hcnt - 8'h01;
      end else begin
        n.hcnt = SPI_HALF_CYC;
        n.sclk = ~r.sclk;
        if (r.sclk) begin
          n.mosi = r.lsb_first ? r.tx[0] : r.tx[7];
          n.tx   = r.lsb_first ? {1'b0, r.tx[7:1]} : {r.tx[6:0], 1'b0};
        end else begin
          n.rx   = r.lsb_first ? {miso_nf, r.rx[7:1]} : {r.rx[6:0], miso_nf};
          n.bcnt = r.bcnt + 4'h1;
          if (r.bcnt == 4'h7) begin
            n.busy = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      r <= rst_val;
    end else begin
      r <= n;
    end
  end

  assign bus.sclk = r.sclk;
  assign bus.mosi = r.mosi;
  assign bus.cs_n = ~r.sel;
  assign rdata_o  = r.rdata;

endmodule

// file: rtl/spbr_pkg.sv
package spbr_pkg;

  // Command opcodes and command arguments.
  localparam logic [7:0] OP_I2C_WRITE  = 8'h00;
  localparam logic [7:0] OP_REG_WRITE  = 8'h20;
  localparam logic [7:0] OP_REG_READ   = 8'h21;
  localparam logic [7:0] OP_SPI_CFG    = 8'h18;
  localparam logic [7:0] CFG_LSB_FIRST = 8'h81;
  localparam logic [7:0] CFG_MSB_FIRST = 8'h42;

  // Internal register addresses and reset values.
  localparam logic [7:0] REG_I2C_CLOCK      = 8'h02;
  localparam logic [7:0] REG_TIME_LIMIT     = 8'h03;
  localparam logic [7:0] REG_OUTCOME        = 8'h04;
  localparam logic [7:0] RST_I2C_CLOCK      = 8'h19;
  localparam logic [7:0] RST_TIME_LIMIT     = 8'h00;
  localparam logic [7:0] RST_OUTCOME        = 8'hf0;

  // Transfer outcome codes.
  localparam logic [7:0] ST_OK        = 8'hf0;
  localparam logic [7:0] ST_ADDR_NAK  = 8'hf1;
  localparam logic [7:0] ST_DATA_NAK  = 8'hf2;
  localparam logic [7:0] ST_BUSY      = 8'hf3;
  localparam logic [7:0] ST_TIMEOUT   = 8'hf8;
  localparam logic [7:0] ST_BAD_COUNT = 8'hf9;

  // Write command framing.
  localparam int         MAX_WRITE_BYTES = 255;
  localparam logic [8:0] FIRST_DATA_IDX  = 9'h003;
  localparam logic [8:0] LAST_DATA_IDX   = 9'h101;

  // Times in picoseconds and the cycle counts derived from them.
  localparam int CLK_PERIOD_PS          = 4000;
  localparam int I2C_BASE_PS            = 66667;
  localparam int I2C_MIN_SCL_PERIOD_PS  = 2500000;
  localparam int SPI_MIN_SCLK_PERIOD_PS = 833334;
  localparam logic [14:0] I2C_Q_SCALE   = 15'((2 * I2C_BASE_PS) / CLK_PERIOD_PS);
  localparam logic [14:0] I2C_Q_MIN_CYC =
    15'((I2C_MIN_SCL_PERIOD_PS + 4 * CLK_PERIOD_PS - 1) / (4 * CLK_PERIOD_PS));
  localparam logic [4:0]  TO_TICK_CYC   = 5'(I2C_BASE_PS / CLK_PERIOD_PS);
  localparam logic [7:0]  SPI_HALF_CYC  =
    8'((SPI_MIN_SCLK_PERIOD_PS + 2 * CLK_PERIOD_PS - 1) / (2 * CLK_PERIOD_PS));

  // Host command port registers.
  localparam logic [7:0] HREG_CTRL = 8'h00;
  localparam logic [7:0] HREG_TX   = 8'h04;
  localparam logic [7:0] HREG_RX   = 8'h08;
  localparam logic [7:0] HREG_STAT = 8'h0c;

  // Synchroniser reset value for lines that idle high.
  localparam logic [2:0] SYNC_HI = 3'b111;

endpackage

// file: rtl/spbr_spi_if.sv
interface spbr_spi_if;
  logic sclk;
  logic mosi;
  logic miso;
  logic cs_n;
  logic int_n;

  modport dev  (input sclk, input mosi, input cs_n, output miso, output int_n);
  modport host (output sclk, output mosi, output cs_n, input miso, input int_n);
endinterface

// file: tb/spbr_bridge_asserts.sv
module spbr_bridge_asserts
  import spbr_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Link between the ends.
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic cs_n,
  input wire logic int_n,
  // I2C wires and the bridge's drivers.
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o
);
  logic [9:0] half_r;
  logic [9:0] per_r;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  // Cycles since the link clock last moved and since SCL last rose.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || $changed(sclk)) begin
      half_r <= 10'h000;
    end else if (half_r != 10'h3ff) begin
      half_r <= half_r + 10'h001;
    end
    if (srst_i || $rose(scl_i)) begin
      per_r <= 10'h000;
    end else if (per_r != 10'h3ff) begin
      per_r <= per_r + 10'h001;
    end
  end

  chk_reset_quiet: assert property ($fell(srst_i) |-> (int_n && !scl_oe_o && !sda_oe_o) [*4])
    else $error("bridge outputs active after reset");
  chk_busy_no_int: assert property ((scl_oe_o || sda_oe_o) |-> int_n)
    else $error("interrupt raised while the I2C bus is driven");
  chk_int_lines_free: assert property ($fell(int_n) |-> !scl_oe_o && !sda_oe_o)
    else $error("interrupt raised before the I2C lines were released");
  chk_mode_idle_high: assert property (cs_n && $past(cs_n) |-> sclk)
    else $error("link clock not idle high while deselected");
  chk_mosi_at_rise: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("mosi moved at the sampling edge");
  chk_miso_deselect: assert property (cs_n [*8] |-> $stable(miso))
    else $error("miso moved while deselected");
  chk_sclk_half_min: assert property ($changed(sclk) |-> half_r >= 10'h067)
    else $error("link clock half period too short");
  chk_scl_period_min: assert property ($rose(scl_i) |-> per_r >= 10'h270)
    else $error("SCL period shorter than the fast rate allows");
  chk_sda_high_phase: assert property ($rose(scl_i) |-> $stable(sda_oe_o) [*8])
    else $error("SDA moved early in the SCL high phase");
  chk_stretch_wait: assert property (!scl_oe_o && !scl_i |=> !scl_oe_o)
    else $error("SCL pulled again while held low by another party");

  cov_int_event: cover property ($fell(int_n));
  cov_stretch: cover property (!scl_oe_o && !scl_i);
  cov_scl_edge: cover property ($rose(scl_i));
endmodule

// file: tb/tb.sv
module tb
  import spbr_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic       ref_clk;
  logic       srst     = 1'b1;
  logic [7:0] addr     = 8'h00;
  logic [7:0] wdata    = 8'h00;
  logic       wr       = 1'b0;
  logic       rd       = 1'b0;
  logic [7:0] rdata;
  logic       scl_oe;
  logic       sda_oe;
  logic       t_scl    = 1'b0;
  logic       t_sda    = 1'b0;
  logic       scl_q    = 1'b1;
  logic       sda_q    = 1'b1;
  logic       ack_addr = 1'b0;
  logic       ack_data = 1'b0;
  logic       stretch  = 1'b0;
  logic       lsb      = 1'b0;
  logic [3:0] bitn     = 4'h0;
  logic [7:0] shreg    = 8'h00;
  logic [7:0] got [4];
  logic [7:0] last_rx;
  int         bytn     = 0;
  int         starts   = 0;
  int         num_errors      = 0;
  int         samples_checked = 0;
  // Open-drain wires with pull-ups.
  wire        i2c_scl  = ~(scl_oe | t_scl);
  wire        i2c_sda  = ~(sda_oe | t_sda);

  spbr_spi_if spi ();
  spbr_host u_spbr_host (.ref_clk_i(ref_clk), .srst_i(srst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
                         .rd_i(rd), .rdata_o(rdata), .bus(spi));
  spbr_dev u_spbr_dev (.ref_clk_i(ref_clk), .srst_i(srst), .bus(spi), .scl_i(i2c_scl), .scl_o(),
                       .scl_oe_o(scl_oe), .sda_i(i2c_sda), .sda_o(), .sda_oe_o(sda_oe));
  spbr_bridge_asserts u_spbr_bridge_asserts (.ref_clk_i(ref_clk), .srst_i(srst), .sclk(spi.sclk),
    .mosi(spi.mosi), .miso(spi.miso), .cs_n(spi.cs_n), .int_n(spi.int_n), .scl_i(i2c_scl),
    .sda_i(i2c_sda), .scl_oe_o(scl_oe), .sda_oe_o(sda_oe));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Target on the I2C bus: captures bytes, acknowledges on request, can hold SCL low after the address.
  always @(posedge ref_clk) begin
    scl_q <= i2c_scl;
    sda_q <= i2c_sda;
    if (i2c_scl && scl_q && sda_q && !i2c_sda) begin
      bitn   <= 4'h0;
      bytn   <= 0;
      starts <= starts + 1;
    end else if (i2c_scl && !scl_q) begin
      shreg <= {shreg[6:0], i2c_sda};
      bitn  <= bitn + 4'h1;
    end else if (!i2c_scl && scl_q && bitn == 4'h8) begin
      t_sda <= (bytn == 0) ? ack_addr : ack_data;
      if (bytn < 4) got[bytn] <= shreg;
    end else if (!i2c_scl && scl_q && bitn == 4'h9) begin
      t_sda <= 1'b0;
      t_scl <= stretch;
      bitn  <= 4'h0;
      bytn  <= bytn + 1;
    end
    if (!stretch && t_scl) t_scl <= 1'b0;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic port_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  task automatic port_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask

  task automatic spi_byte(input logic [7:0] b);
    logic [7:0] s;
    port_wr(HREG_TX, b);
    s = 8'h01;
    for (int i = 0; i < 2000 && s[0] !== 1'b0; i++) port_rd(HREG_STAT, s);
    check("port busy", {7'h00, s[0]}, 8'h00);
    port_rd(HREG_RX, last_rx);
  endtask

  task automatic cmd(input int n, input logic [7:0] b0, b1, b2 = 8'h00, b3 = 8'h00, b4 = 8'h00);
    logic [7:0] b [5];
    b = '{b0, b1, b2, b3, b4};
    port_wr(HREG_CTRL, {6'h00, lsb, 1'b1});
    for (int i = 0; i < n; i++) spi_byte(b[i]);
    port_wr(HREG_CTRL, {6'h00, lsb, 1'b0});
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    cmd(3, OP_REG_READ, a, 8'h00);
    check("register value", last_rx, exp);
  endtask

  task automatic wait_int();
    for (int i = 0; i < 60000 && spi.int_n !== 1'b0; i++) @(posedge ref_clk);
    check("interrupt line", spi.int_n, 1'b0);
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    // Some 54 link bytes of about 1700 cycles each plus three short I2C transfers and one that times out.
    repeat (200000) @(posedge ref_clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    logic [7:0] s;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check("interrupt line", spi.int_n, 1'b1);
    port_rd(HREG_STAT, s);
    check("port status", s, 8'h00);
    port_rd(8'h10, s);
    check("unmapped port", s, 8'h00);
    reg_read(REG_OUTCOME, RST_OUTCOME);
    // Both ends switch to LSB first, then back.
    cmd(2, OP_SPI_CFG, CFG_LSB_FIRST);
    lsb = 1'b1;
    reg_read(REG_I2C_CLOCK, RST_I2C_CLOCK);
    cmd(2, OP_SPI_CFG, CFG_MSB_FIRST);
    lsb = 1'b0;
    cmd(3, OP_REG_WRITE, REG_I2C_CLOCK, 8'h00);
    // A zero count is refused without touching the I2C bus.
    cmd(3, OP_I2C_WRITE, 8'h00, 8'ha2);
    wait_int();
    check("start count", 8'(starts), 8'h00);
    reg_read(REG_OUTCOME, ST_BAD_COUNT);
    cmd(4, OP_I2C_WRITE, 8'h01, 8'ha0, 8'h55);
    wait_int();
    check("address byte", got[0], 8'ha0);
    reg_read(REG_OUTCOME, ST_ADDR_NAK);
    ack_addr <= 1'b1;
    ack_data <= 1'b1;
    cmd(5, OP_I2C_WRITE, 8'h02, 8'h51, 8'h3c, 8'hc3);
    check("interrupt line", spi.int_n, 1'b1);
    reg_read(REG_OUTCOME, ST_BUSY);
    wait_int();
    port_rd(HREG_STAT, s);
    check("port status", s, 8'h02);
    reg_read(REG_OUTCOME, ST_OK);
    check("address byte", got[0], 8'h50);
    check("data byte", got[1], 8'h3c);
    check("data byte", got[2], 8'hc3);
    ack_data <= 1'b0;
    cmd(4, OP_I2C_WRITE, 8'h01, 8'h52, 8'haa);
    wait_int();
    reg_read(REG_OUTCOME, ST_DATA_NAK);
    // The target holds SCL low after the address until the time limit runs out.
    cmd(3, OP_REG_WRITE, REG_TIME_LIMIT, 8'h01);
    ack_data <= 1'b1;
    stretch  <= 1'b1;
    cmd(4, OP_I2C_WRITE, 8'h01, 8'h52, 8'haa);
    wait_int();
    stretch  <= 1'b0;
    reg_read(REG_OUTCOME, ST_TIMEOUT);
    give_verdict();
  end
endmodule
